// file: wtc_pkg.sv
// wtc_pkg: constants for the waveform trigger control block.
// assumes a single 125 MHz system clock standing in for the selected source.
`default_nettype none
package wtc_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] WTC_CTRL_OFS = 8'h00;
    localparam logic [7:0] WTC_PERIOD_OFS = 8'h04;
    localparam logic [7:0] WTC_CMD_OFS = 8'h08;
    localparam logic [7:0] WTC_STATUS_OFS = 8'h0C;

    // ctrl fields
    localparam int WTC_CTRL_WAIT_BIT = 0;
    localparam int WTC_CTRL_SLOW_BIT = 1;
    localparam int WTC_CTRL_SRC_LSB = 2;
    localparam int WTC_SRC_NUM = 5;
    localparam logic [31:0] WTC_CTRL_RST = 32'h0000_0001;

    // cmd fields, write one to act
    localparam int WTC_CMD_PLAY_BIT = 0;
    localparam int WTC_CMD_TRIG_BIT = 1;
    localparam int WTC_CMD_STOP_BIT = 2;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int WTC_CLK_PERIOD_PS = 8000;
    localparam int WTC_BLOCK_SAMPLES = 80;
    localparam int WTC_FAST_LAT_HALF = 32480;
    localparam int WTC_SLOW_LAT_HALF = 30880;
    localparam int WTC_FAST_LAT_CYC = WTC_FAST_LAT_HALF / 2;
    localparam int WTC_SLOW_LAT_CYC = WTC_SLOW_LAT_HALF / 2;
    localparam int WTC_HOLDOFF_PS = 1400000;
    localparam int WTC_HOLDOFF_CYC = WTC_HOLDOFF_PS / WTC_CLK_PERIOD_PS + 1;
    localparam int WTC_INT_MIN_PS = 1000000;
    localparam int WTC_INT_MIN_CYC =
        (WTC_INT_MIN_PS + WTC_CLK_PERIOD_PS - 1) / WTC_CLK_PERIOD_PS;
    localparam longint WTC_INT_MAX_S = 10;
    localparam int WTC_INT_MAX_CYC =
        int'(WTC_INT_MAX_S * 64'h0000_00E8_D4A5_1000 / WTC_CLK_PERIOD_PS);
    localparam logic [31:0] WTC_PERIOD_RST = 32'h0000_007D;

    typedef enum logic [2:0] {
        WTC_IDLE,
        WTC_ARMED,
        WTC_DELAY,
        WTC_PLAY,
        WTC_HOLDOFF
    } wtc_state_t;

endpackage
`default_nettype wire

// file: wtc_top.sv
// wtc_top: trigger qualification and playout start, apb register access.
// assumes sys_clk_in is the selected clock; playout logic reports wave end.
//
// Behaviour
// - waiting runs start only on post-play trigger
// - five trigger origins, internal 1us..10s
// - detection runs on the selected clock
// - slow timing clock is source divided 80
// - fast latency is 32480 half periods
// - slow latency is 30880 half periods
// - triggers ignored over 1.4us after waveform
// - memory read in 80-sample blocks, aligned
// - fast uncertainty about half sample period
// - sample clock range; rate derived by scaling
// - fast samples every edge, slow on tick
// - off-window trigger lands in adjacent cycle
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wtc_top
#(
    parameter int FAST_LAT_CYC = wtc_pkg::WTC_FAST_LAT_CYC,
    parameter int SLOW_LAT_CYC = wtc_pkg::WTC_SLOW_LAT_CYC,
    parameter int INT_MAX_CYC = wtc_pkg::WTC_INT_MAX_CYC
)
(
    input wire logic sys_clk_in, // selected clock
    input wire logic sys_rst_in, // sync reset, high
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [7:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error
    input wire logic ext_a_in, // external trigger a pin
    input wire logic ext_b_in, // external trigger b pin
    input wire logic jump_in, // sequence jump pin
    input wire logic manual_in, // manual trigger control
    input wire logic wave_done_in, // playout reached waveform end
    output logic start_out, // one-cycle start of analog output
    output logic block_rd_out, // 80-sample block read strobe
    output logic playing_out // playout active
);
    import wtc_pkg::*;

    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic [31:0] clamp_period(input logic [31:0] p);
        logic [31:0] r;
        r = p;
        if (p < 32'(WTC_INT_MIN_CYC))
            r = 32'(WTC_INT_MIN_CYC);
        else if (p > 32'(INT_MAX_CYC))
            r = 32'(INT_MAX_CYC);
        return r;
    endfunction

    // ***************************************************************
    // registers
    // ***************************************************************
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] period_reg, period_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic play_cmd, trig_cmd, stop_cmd;
    logic setup_ph, wr_acc, cmd_wr;
    wtc_state_t state_reg, state_next;

    assign setup_ph = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign cmd_wr = wr_acc && paddr_in == WTC_CMD_OFS;
    assign play_cmd = cmd_wr && pwdata_in[WTC_CMD_PLAY_BIT];
    assign trig_cmd = cmd_wr && pwdata_in[WTC_CMD_TRIG_BIT];
    assign stop_cmd = cmd_wr && pwdata_in[WTC_CMD_STOP_BIT];

    always_comb
    begin
        ctrl_next = ctrl_reg;
        period_next = period_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup_ph)
        begin
            err_next = 1'b0;
            rdata_next = 32'h0000_0000;
            case (paddr_in)
                WTC_CTRL_OFS: rdata_next = ctrl_reg;
                WTC_PERIOD_OFS: rdata_next = period_reg;
                WTC_CMD_OFS: rdata_next = 32'h0000_0000;
                WTC_STATUS_OFS: rdata_next = {29'h0, state_reg};
                default: err_next = 1'b1;
            endcase
        end
        if (wr_acc && paddr_in == WTC_CTRL_OFS)
            ctrl_next = {25'h0, pwdata_in[6:0]};
        if (wr_acc && paddr_in == WTC_PERIOD_OFS)
            period_next = pwdata_in;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_reg <= WTC_CTRL_RST;
            period_reg <= WTC_PERIOD_RST;
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            period_reg <= period_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    assign pready_out = 1'b1;
    assign prdata_out = rdata_reg;
    assign pslverr_out = psel_in && penable_in && err_reg;

    // ***************************************************************
    // pin synchronisers and trigger edges
    // ***************************************************************
    logic [3:0] meta_reg, sync_reg, prev_reg;
    logic [3:0] meta_next, sync_next, prev_next;
    logic [3:0] pin_edge;

    always_comb
    begin
        meta_next = {manual_in, jump_in, ext_b_in, ext_a_in};
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            prev_reg <= 4'h0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    assign pin_edge = sync_reg & ~prev_reg;

    // ***************************************************************
    // internal generator, sync divider, trigger gating
    // ***************************************************************
    logic [31:0] int_cnt_reg, int_cnt_next;
    logic [6:0] div_reg, div_next;
    logic [15:0] cnt_reg, cnt_next;
    logic pend_reg, pend_next;
    logic int_tick, sync_tick, slow_mode, raw_trig, trig_take;
    logic [4:0] src_hit;

    assign slow_mode = ctrl_reg[WTC_CTRL_SLOW_BIT];
    assign int_tick = int_cnt_reg >= clamp_period(period_reg) - 32'h1;
    assign sync_tick = div_reg == 7'(WTC_BLOCK_SAMPLES - 1);
    assign src_hit = {pin_edge, int_tick};
    assign raw_trig = |(src_hit & ctrl_reg[WTC_CTRL_SRC_LSB +: WTC_SRC_NUM])
        || trig_cmd;
    // fast takes every cycle; slow holds a pending edge to the next tick
    assign trig_take = slow_mode ? (pend_reg || raw_trig) && sync_tick
        : raw_trig;

    always_comb
    begin
        int_cnt_next = int_tick ? 32'h0 : int_cnt_reg + 32'h1;
        div_next = sync_tick ? 7'h00 : div_reg + 7'h01;
        pend_next = pend_reg;
        if (state_reg != WTC_ARMED || trig_take)
            pend_next = 1'b0;
        else if (raw_trig)
            pend_next = 1'b1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            int_cnt_reg <= 32'h0;
            div_reg <= 7'h00;
            pend_reg <= 1'b0;
        end
        else
        begin
            int_cnt_reg <= int_cnt_next;
            div_reg <= div_next;
            pend_reg <= pend_next;
        end
    end

    // ***************************************************************
    // start sequencer
    // ***************************************************************
    logic fire, start_next, blk_next, play_next;

    assign fire = state_reg == WTC_ARMED
        && (trig_take || !ctrl_reg[WTC_CTRL_WAIT_BIT]);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            WTC_IDLE:
                if (play_cmd)
                    state_next = WTC_ARMED;
            WTC_ARMED:
                if (fire)
                begin
                    state_next = WTC_DELAY;
                    cnt_next = slow_mode ? 16'(SLOW_LAT_CYC - 1)
                        : 16'(FAST_LAT_CYC - 1);
                end
            WTC_DELAY:
                if (cnt_reg == 16'h0)
                    state_next = WTC_PLAY;
                else
                    cnt_next = cnt_reg - 16'h1;
            WTC_PLAY:
                if (wave_done_in)
                begin
                    state_next = WTC_HOLDOFF;
                    cnt_next = 16'(WTC_HOLDOFF_CYC - 1);
                end
            WTC_HOLDOFF:
                if (cnt_reg == 16'h0)
                    state_next = WTC_ARMED;
                else
                    cnt_next = cnt_reg - 16'h1;
            default:
                state_next = WTC_IDLE;
        endcase
        if (stop_cmd)
            state_next = WTC_IDLE;
        start_next = state_reg == WTC_DELAY && cnt_reg == 16'h0
            && !stop_cmd;
        blk_next = state_next == WTC_PLAY && div_next == 7'h00;
        play_next = state_next == WTC_PLAY;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= WTC_IDLE;
            cnt_reg <= 16'h0;
            start_out <= 1'b0;
            block_rd_out <= 1'b0;
            playing_out <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            start_out <= start_next;
            block_rd_out <= blk_next;
            playing_out <= play_next;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_wait_needs_trig: assert property (
        state_reg == WTC_ARMED && ctrl_reg[WTC_CTRL_WAIT_BIT] && !trig_take
        |=> state_reg != WTC_DELAY)
        else $error("start without qualified trigger");
    a_slow_on_tick: assert property (
        state_reg == WTC_ARMED && state_next == WTC_DELAY && slow_mode
        && ctrl_reg[WTC_CTRL_WAIT_BIT] |-> sync_tick)
        else $error("slow trigger taken off tick");
    a_div_period: assert property (
        sync_tick |=> !sync_tick [*8])
        else $error("sync divider too short");
    a_div_wrap: assert property (
        sync_tick |=> div_reg == 7'h00)
        else $error("sync divider wrap wrong");
    a_hold_ignores: assert property (
        state_reg == WTC_HOLDOFF && cnt_reg != 16'h0 && !stop_cmd
        |=> state_reg == WTC_HOLDOFF)
        else $error("holdoff ended early");
    a_hold_load: assert property (
        state_reg == WTC_PLAY && wave_done_in && !stop_cmd
        |=> state_reg == WTC_HOLDOFF && cnt_reg == 16'(WTC_HOLDOFF_CYC - 1))
        else $error("holdoff length wrong");
    a_hold_len: assert property (
        state_reg == WTC_HOLDOFF && cnt_reg == 16'h0 && !stop_cmd
        |=> state_reg == WTC_ARMED)
        else $error("holdoff exit wrong");
    a_lat_load: assert property (
        state_reg == WTC_ARMED && state_next == WTC_DELAY && !stop_cmd
        |=> cnt_reg == (slow_mode ? 16'(SLOW_LAT_CYC - 1)
        : 16'(FAST_LAT_CYC - 1)))
        else $error("latency count wrong");
    a_start_after: assert property (
        state_reg == WTC_DELAY && cnt_reg == 16'h0 && !stop_cmd
        |=> start_out ##1 !start_out)
        else $error("start pulse wrong");
    a_blk_align: assert property (
        block_rd_out |-> div_reg == 7'h00)
        else $error("block read misaligned");
    a_one_edge: assert property (
        pin_edge[0] |=> !pin_edge[0])
        else $error("edge repeated");
    a_pend_kept: assert property (
        state_reg == WTC_ARMED && slow_mode && raw_trig && !sync_tick
        && !stop_cmd |=> pend_reg)
        else $error("off-tick trigger lost");

    c_fast_start: cover property (fire && !slow_mode);
    c_slow_start: cover property (fire && slow_mode);
    c_holdoff: cover property (state_reg == WTC_HOLDOFF);
    c_pending: cover property (pend_reg && sync_tick);

endmodule
`default_nettype wire

// file: wtc_trig_src.sv
// wtc_trig_src: far-side model of the external trigger source.
// assumes one pulse request at a time, on the device clock.
`timescale 1ns/1ps
`default_nettype none
module wtc_trig_src
(
    input wire logic clk_in, // clock shared with the device
    input wire logic go_in, // launch one pulse
    input wire logic [1:0] sel_in, // 0 a, 1 b, 2 jump, 3 manual
    input wire logic [15:0] width_in, // pulse width in cycles
    output logic [3:0] pins_out // a, b, jump, manual
);
    int left = 0;
    // edges launched from the device clock; released lines pulled low
    always @(posedge clk_in)
    begin
        if (go_in)
        begin
            left <= int'(width_in);
            pins_out <= 4'h1 << sel_in;
        end
        else if (left > 1)
            left <= left - 1;
        else
            pins_out <= 4'h0;
    end
endmodule
`default_nettype wire

// file: wtc_top_test.sv
// wtc_top_test: self-checking bench for the trigger control block.
// assumes wtc_pkg, wtc_top and wtc_trig_src are compiled first.
`timescale 1ns/1ps
`default_nettype none
module wtc_top_test;
    import wtc_pkg::*;
    localparam int FL = 20;
    localparam int SL = 10;
    typedef struct {logic [31:0] ctrl; int src; int lo; int hi;} wtc_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, start, blk, playing, e;
    logic done = 1'b0;
    logic go = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [15:0] width = 16'h0005;
    logic [31:0] d;
    wire logic [3:0] pins;
    int n_fail = 0;
    int checks_done = 0;
    int lat;
    // ctrl, source (0 a 1 b 2 jump 3 manual 4 cmd 5 internal 6 none), window
    wtc_row_t rows [9] = '{
        '{32'h0000_0009, 0, 23, 25}, '{32'h0000_0011, 1, 23, 25},
        '{32'h0000_0021, 2, 23, 25}, '{32'h0000_0041, 3, 23, 25},
        '{32'h0000_0001, 4, 19, 25}, '{32'h0000_0005, 5, 1, 150},
        '{32'h0000_000B, 0, 13, 95}, '{32'h0000_0003, 4, 9, 95},
        '{32'h0000_0000, 6, 18, 28}};

    wtc_top #(.FAST_LAT_CYC(FL), .SLOW_LAT_CYC(SL), .INT_MAX_CYC(1000)) dut_u (
        .sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .ext_a_in(pins[0]), .ext_b_in(pins[1]),
        .jump_in(pins[2]), .manual_in(pins[3]), .wave_done_in(done),
        .start_out(start), .block_rd_out(blk), .playing_out(playing));
    wtc_trig_src src_u (.clk_in(clk), .go_in(go), .sel_in(sel),
        .width_in(width), .pins_out(pins));

    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo(input string nm);
        n_fail++;
        $display("Error %s exp done seen timeout", nm);
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            tmo("pready");
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
        input string nm);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, d, x);
    endtask
    task automatic fire(input int s, input logic [15:0] w);
        if (s < 4)
        begin
            @(posedge clk);
            sel <= 2'(s);
            width <= w;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
        end
        else if (s == 4)
            apb(1'b1, WTC_CMD_OFS, 32'h0000_0002);
    endtask
    task automatic wait_start(input int lim);
        lat = 0;
        do
        begin
            @(posedge clk);
            #1;
            lat++;
        end
        while (start !== 1'b1 && lat < lim);
    endtask
    task automatic expect_start(input int lo, input int hi);
        wait_start(300);
        if (start !== 1'b1)
            tmo("start");
        check("latency", lat >= lo && lat <= hi, 1'b1);
    endtask
    task automatic no_start(input int n, input string nm);
        wait_start(n);
        check(nm, start, 1'b0);
    endtask
    task automatic blk_gap();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (blk !== 1'b1 && n < 200);
        if (n >= 200)
            tmo("block_rd");
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (blk !== 1'b1 && n < 200);
        check("block_gap", n, 80);
    endtask
    task automatic end_wave();
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        #1;
        check("playing_end", playing, 1'b0);
    endtask

    // ***************************************************************
    // clock and main sequence
    // ***************************************************************
    initial
    begin
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            apb(1'b1, WTC_CTRL_OFS, rows[i].ctrl);
            apb(1'b1, WTC_CMD_OFS, 32'h0000_0001);
            if (rows[i].ctrl[0] && rows[i].src != 5)
                rd_chk(WTC_STATUS_OFS, 32'h0000_0001, "armed");
            fire(rows[i].src, 16'h003C);
            expect_start(rows[i].lo, rows[i].hi);
            check("playing", playing, 1'b1);
            blk_gap();
            end_wave();
            rd_chk(WTC_STATUS_OFS, 32'h0000_0004, "holdoff");
            apb(1'b1, WTC_CMD_OFS, 32'h0000_0004);
            rd_chk(WTC_STATUS_OFS, 32'h0000_0000, "stopped");
            $display("test row %0d done", i);
        end
        apb(1'b1, WTC_CTRL_OFS, 32'h0000_0019);
        fire(0, 16'h0005);
        no_start(60, "early_start");
        $display("test pre_play done");
        apb(1'b1, WTC_CMD_OFS, 32'h0000_0001);
        fire(0, 16'h0190);
        expect_start(23, 25);
        end_wave();
        no_start(50, "holdoff_a");
        fire(1, 16'h0005);
        no_start(200, "holdoff_b");
        rd_chk(WTC_STATUS_OFS, 32'h0000_0001, "rearmed");
        fire(1, 16'h0005);
        expect_start(23, 25);
        $display("test holdoff done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("rst_playing", playing, 1'b0);
        check("rst_ready", pready, 1'b1);
        check("rst_start", start, 1'b0);
        check("rst_block", blk, 1'b0);
        check("rst_prdata", prdata, 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(WTC_CTRL_OFS, WTC_CTRL_RST, "ctrl_rst");
        rd_chk(WTC_PERIOD_OFS, WTC_PERIOD_RST, "period_rst");
        rd_chk(WTC_STATUS_OFS, 32'h0000_0000, "status_rst");
        apb(1'b1, WTC_CTRL_OFS, 32'hFFFF_FFFF);
        rd_chk(WTC_CTRL_OFS, 32'h0000_007F, "ctrl_mask");
        rd_chk(WTC_CMD_OFS, 32'h0000_0000, "cmd_wo");
        rd_chk(8'h10, 32'h0000_0000, "unmapped");
        check("slverr", e, 1'b1);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
